// >>> logic/pif_pkg.sv
// Package of constants for the interrupt flag and mask block
// Behaviour
// (R1) Bit 5 latches switch three thermal fault
// (R2) Bit 4 latches switch two thermal/undervoltage fault
// (R3) Bit 3 latches switch one thermal fault
// (R4) Bits 2..0 follow live current-limit state
// (R5) Unmasked event pulls interrupt low; masks reset 0
// (R6) Masked event never touches interrupt output
// (R7) Masks never gate detection or flag capture
// (R8) Mask bit 5 gates programming-voltage-low event
// (R9) Mask bit 4 gates adapter-detect change event
// (R10) Mask bit 3 gates push-button change event
// (R11) Mask bits 2..0: thermal, coin-cell, prog-done
// (R12) Interrupt low while any unmasked flag set
// (R13) Reserved bits read 0; status read-only
package pif_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] PIF_OFS_SWITCH_FAULT_STATUS = 8'h02;
    localparam logic [7:0] PIF_OFS_EVENT_MASK_PRIMARY  = 8'h03;
    localparam logic [5:0] PIF_RST_EVENT_MASK_PRIMARY  = 6'h00;
    localparam logic [5:0] PIF_RST_SWITCH_FAULT_STATUS = 6'h00;
    // ==========================================================
    // Field positions, status register
    localparam int PIF_BIT_SW_THREE_FAULT  = 5;
    localparam int PIF_BIT_SW_TWO_FAULT    = 4;
    localparam int PIF_BIT_SW_ONE_FAULT    = 3;
    localparam int PIF_BIT_SW_THREE_ILIMIT = 2;
    localparam int PIF_BIT_SW_TWO_ILIMIT   = 1;
    localparam int PIF_BIT_SW_ONE_ILIMIT   = 0;
    // ==========================================================
    // Field positions, primary mask register
    localparam int PIF_BIT_PROG_VOLTAGE_MASK   = 5;
    localparam int PIF_BIT_ADAPTER_DETECT_MASK = 4;
    localparam int PIF_BIT_PUSH_BUTTON_MASK    = 3;
    localparam int PIF_BIT_THERMAL_WARN_MASK   = 2;
    localparam int PIF_BIT_COIN_CELL_DONE_MASK = 1;
    localparam int PIF_BIT_PROG_COMPLETE_MASK  = 0;
    // ==========================================================
    // Widths
    localparam int PIF_FLAG_W = 6;
endpackage

// >>> logic/pif_flag_if.sv
// Interface carrying captured flags and their clear request
`timescale 1ns/1ps
`default_nettype none
interface pif_flag_if;
    logic [5:0] flags;    // Captured status flags
    logic       clrReq;   // Clear-on-read pulse for sticky faults
    modport cap  (output flags, input  clrReq);
    modport core (input  flags, output clrReq);
endinterface
`default_nettype wire

// >>> logic/pif_flag_capture.sv
// Synchroniser and flag capture for load-switch fault and limit inputs
`timescale 1ns/1ps
`default_nettype none
module pif_flag_capture
    import pif_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Raw analog detector levels
    input  wire logic [2:0] swFaultRaw,
    input  wire logic [2:0] swIlimitRaw,
    // Flags toward the register core
    pif_flag_if.cap         flagBus
);
    // ==========================================================
    // Three-stage synchroniser
    logic [5:0] syncA;     // First stage, read only by syncB
    logic [5:0] syncB;     // Second stage
    logic [5:0] syncC;     // Third stage
    logic [5:0] filt;      // Accepted level once B and C agree
    logic [2:0] faultSticky; // Latched fault flags
    logic [5:0] rawAll;    // Fault bits above limit bits
    assign rawAll = {swFaultRaw, swIlimitRaw};

    // Shift detector levels through three flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 6'h00;
            syncB <= 6'h00;
            syncC <= 6'h00;
        end else begin
            syncA <= rawAll;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // Accept a change only when two stages agree, rejects metastable glitches
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt <= 6'h00;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (syncB[i] == syncC[i]) begin
                    filt[i] <= syncC[i];
                end
            end
        end
    end

    // Sticky fault flags; a fault present at clear time wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            faultSticky <= PIF_RST_SWITCH_FAULT_STATUS[5:3];
        end else begin
            faultSticky <= (flagBus.clrReq ? 3'h0 : faultSticky) | filt[5:3]; // R1 R2 R3
        end
    end

    // Faults latched, limit bits live so they drop when limiting ends
    assign flagBus.flags = {faultSticky, filt[2:0]}; // R4

    // ==========================================================
    // Checks
    AST_FAULT_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
        swFaultRaw[2] [*5] |-> ##[0:1] flagBus.flags[PIF_BIT_SW_THREE_FAULT])
        else $error("switch three fault not latched");
    AST_FAULT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
        flagBus.flags[PIF_BIT_SW_ONE_FAULT] && !flagBus.clrReq
        |=> flagBus.flags[PIF_BIT_SW_ONE_FAULT])
        else $error("switch one fault dropped without clear");
    AST_FAULT_TWO: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
        swFaultRaw[1] [*5] |-> ##[0:1] flagBus.flags[PIF_BIT_SW_TWO_FAULT])
        else $error("switch two fault not latched");
    AST_ILIMIT_LIVE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        !swIlimitRaw[0] [*6] |-> !flagBus.flags[PIF_BIT_SW_ONE_ILIMIT])
        else $error("limit flag stuck after limiting ended");
    AST_ILIMIT_SET: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        swIlimitRaw[2] [*6] |-> flagBus.flags[PIF_BIT_SW_THREE_ILIMIT])
        else $error("limit flag missing while limiting");
    COV_FAULT_CLEARED: cover property (@(posedge ref_clk) disable iff (!rst_n)
        flagBus.flags[PIF_BIT_SW_TWO_FAULT] ##1 !flagBus.flags[PIF_BIT_SW_TWO_FAULT]);
endmodule
`default_nettype wire

// >>> logic/pif_flags_masks.sv
// Top of the interrupt flag and mask block with its register port
`timescale 1ns/1ps
`default_nettype none
module pif_flags_masks
    import pif_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regWrData,
    output logic [7:0]      regRdData,
    output logic            regRdValid,
    // Detector inputs, asynchronous
    input  wire logic [2:0] swFaultRaw,
    input  wire logic [2:0] swIlimitRaw,
    // Primary event flags from on-chip logic, same clock
    input  wire logic [5:0] primaryEventFlags,
    // Interrupt pin, active low
    output logic            irq_out_n
);
    // ==========================================================
    // Internal state
    pif_flag_if flagBus ();                 // Capture to core
    logic [5:0] eventMaskPrimary;           // Primary mask register
    logic       next_irqActive;             // Combined interrupt request
    logic       statusRead;                 // Status register read this cycle
    logic       maskWrite;                  // Mask register written this cycle
    logic [5:0] unmaskedPrimary;            // Primary events passing their masks
    logic       anySwitchFlag;              // Any switch fault or limit flag set

    // ==========================================================
    // Decode helpers
    // Status register offset match, used by strobe decode and read mux
    function automatic logic isStatusAddr(input logic [7:0] addr);
        return addr == PIF_OFS_SWITCH_FAULT_STATUS;
    endfunction

    // Mask register offset match, used by strobe decode and read mux
    function automatic logic isMaskAddr(input logic [7:0] addr);
        return addr == PIF_OFS_EVENT_MASK_PRIMARY;
    endfunction

    // A mask bit at 0 lets its event through, at 1 blocks it
    function automatic logic [5:0] unmaskedOf(input logic [5:0] events,
                                              input logic [5:0] mask);
        return events & ~mask;
    endfunction

    // ==========================================================
    // Flag capture
    // Detector levels come from the analog side on no clock of ours;
    // the capture module synchronises them before anything looks.
    // Flag capture is independent of every mask
    pif_flag_capture pif_flag_capture_inst ( // R7
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .swFaultRaw  (swFaultRaw),
        .swIlimitRaw (swIlimitRaw),
        .flagBus     (flagBus.cap)
    );

    // ==========================================================
    // Register decode
    // Port contract: one-cycle strobes, decoded on the edge they are
    // seen; read data and valid stand for exactly the next cycle.
    // A read and a mask write on one edge return the old mask.
    // Read strobe aimed at the status register
    assign statusRead     = regRdEn && isStatusAddr(regAddr);
    // Write strobe aimed at the mask register; other offsets fall away
    assign maskWrite      = regWrEn && isMaskAddr(regAddr);
    // Reading the status register clears latched faults; a fault still
    // present on that edge sets the flag again, so none is lost
    assign flagBus.clrReq = statusRead;

    // Mask write; status writes are dropped, it is read-only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eventMaskPrimary <= PIF_RST_EVENT_MASK_PRIMARY; // R5
        end else if (maskWrite) begin
            // Write bits 7:6 are reserved and simply dropped
            eventMaskPrimary <= regWrData[5:0]; // R8 R9 R10 R11 R13
        end
    end

    // Registered read data; reserved bits and unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (!regRdEn) begin
                // Idle cycle: zero, so old data is never taken for new
                regRdData <= 8'h00;
            end else if (isStatusAddr(regAddr)) begin
                // Flags as they stood before this edge's clear
                regRdData <= {2'h0, flagBus.flags}; // R13
            end else if (isMaskAddr(regAddr)) begin
                // Mask before any write on this same edge
                regRdData <= {2'h0, eventMaskPrimary}; // R13
            end else begin
                // Unmapped offset answers zero with valid high
                regRdData <= 8'h00;
            end
        end
    end

    // ==========================================================
    // Interrupt combine
    // The pin is a registered level: it falls one cycle after a cause
    // appears and rises one cycle after the last cause is gone. A host
    // that masks an event sees the pin rise one cycle after the write.
    // Switch flags bypass the primary masks on purpose; their own mask
    // register is not part of this block, so every switch flag counts.
    // Primary events that pass their masks; masked ones are dropped here only
    assign unmaskedPrimary = unmaskedOf(primaryEventFlags, eventMaskPrimary); // R5 R6
    // Switch flags have no mask here, their mask lives elsewhere
    assign anySwitchFlag   = |flagBus.flags; // R12

    // Any passing event or switch flag asks for the pin
    always_comb begin
        next_irqActive = (|unmaskedPrimary) // R5 R6
                       | anySwitchFlag; // R12
    end

    // Registered pin so it never glitches
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~next_irqActive; // R12
        end
    end

    // ==========================================================
    // Checks
    AST_UNMASKED_PULLS: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        |(primaryEventFlags & ~eventMaskPrimary) |=> !irq_out_n)
        else $error("unmasked event did not pull interrupt low");
    AST_MASKED_SILENT: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        (primaryEventFlags != 6'h00) && ((primaryEventFlags & ~eventMaskPrimary) == 6'h00)
        && (flagBus.flags == 6'h00) |=> irq_out_n)
        else $error("masked event reached interrupt");
    AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        !next_irqActive |=> irq_out_n)
        else $error("interrupt held with no unmasked flag");
    AST_MASK_READBACK: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
        regWrEn && !regRdEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)
        ##1 regRdEn && !regWrEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)
        |=> regRdData[5:0] == $past(regWrData[5:0], 2))
        else $error("mask readback mismatch");
    AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        regRdValid |-> regRdData[7:6] == 2'h0)
        else $error("reserved bits not zero");
    AST_STATUS_RO: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        regWrEn && (regAddr == PIF_OFS_SWITCH_FAULT_STATUS)
        && (regAddr != PIF_OFS_EVENT_MASK_PRIMARY) |=> $stable(eventMaskPrimary))
        else $error("status write disturbed masks");
    AST_MONITOR_UNGATED: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
        statusRead |=> regRdData[5:0] == $past(flagBus.flags))
        else $error("status read does not show captured flags");

    // Each mask field takes its own write bit
    AST_MASK_FIELD_FIVE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
        regWrEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)
        |=> eventMaskPrimary[PIF_BIT_PROG_VOLTAGE_MASK]
            == $past(regWrData[PIF_BIT_PROG_VOLTAGE_MASK]))
        else $error("programming voltage mask did not take write");
    AST_MASK_FIELD_FOUR: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
        regWrEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)
        |=> eventMaskPrimary[PIF_BIT_ADAPTER_DETECT_MASK]
            == $past(regWrData[PIF_BIT_ADAPTER_DETECT_MASK]))
        else $error("adapter detect mask did not take write");
    AST_MASK_FIELD_THREE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        regWrEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)
        |=> eventMaskPrimary[PIF_BIT_PUSH_BUTTON_MASK]
            == $past(regWrData[PIF_BIT_PUSH_BUTTON_MASK]))
        else $error("push button mask did not take write");
    AST_MASK_FIELD_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
        regWrEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)
        |=> eventMaskPrimary[PIF_BIT_THERMAL_WARN_MASK:PIF_BIT_PROG_COMPLETE_MASK]
            == $past(regWrData[PIF_BIT_THERMAL_WARN_MASK:PIF_BIT_PROG_COMPLETE_MASK]))
        else $error("low mask fields did not take write");

    // Mask only moves on its own write; status writes leave it alone
    AST_MASK_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        !(regWrEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)) |=> $stable(eventMaskPrimary))
        else $error("mask moved without a write");

    // Latched or live switch flags reach the pin one cycle later
    AST_SWITCH_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        (flagBus.flags != 6'h00) |=> !irq_out_n)
        else $error("switch flag did not pull interrupt low");

    // Every read strobe is answered on the next cycle
    AST_READ_VALID: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        regRdEn |=> regRdValid)
        else $error("read not answered");

    // No read, no data: the port never shows a stale word
    AST_IDLE_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        !regRdEn |=> (regRdData == 8'h00) && !regRdValid)
        else $error("read port busy with no read");

    // Scenarios worth seeing at least once
    COV_MASK_THEN_EVENT: cover property (@(posedge ref_clk) disable iff (!rst_n)
        eventMaskPrimary[PIF_BIT_PUSH_BUTTON_MASK]
        && primaryEventFlags[PIF_BIT_PUSH_BUTTON_MASK] && irq_out_n);
    COV_IRQ_PULSE: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_out_n ##1 !irq_out_n ##[1:20] irq_out_n);
    COV_STATUS_READ: cover property (@(posedge ref_clk) disable iff (!rst_n)
        statusRead ##1 regRdData[PIF_BIT_SW_THREE_FAULT]);
    // Write then read of the mask on back-to-back edges
    COV_BACK_TO_BACK: cover property (@(posedge ref_clk) disable iff (!rst_n)
        maskWrite ##1 (regRdEn && (regAddr == PIF_OFS_EVENT_MASK_PRIMARY)));
endmodule
`default_nettype wire

// >>> tb/pif_host_model.sv
// Host processor model driving the register port of the flag and mask block
`timescale 1ns/1ps
`default_nettype none
module pif_host_model
    import pif_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Register port toward the block
    output logic [7:0]      regAddr,
    output logic            regWrEn,
    output logic            regRdEn,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    // ==========================================================
    // Idle bus
    initial begin
        regAddr   = 8'h00;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
        regWrData = 8'h00;
    end
    // ==========================================================
    // One write: launched after an edge, taken at the next
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        #1;
        regAddr   = addr;
        regWrData = data;
        regWrEn   = 1'b1;
        @(posedge ref_clk);
        #1;
        regWrEn   = 1'b0;
        regWrData = ~data;   // Released data shows inverse, not a stale copy
    endtask
    // Write, then read the same offset on the very next edge
    task automatic wrrd(input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] data, output logic valid);
        @(posedge ref_clk);
        #1;
        regAddr   = addr;
        regWrData = wdata;
        regWrEn   = 1'b1;
        @(posedge ref_clk);
        #1;
        regWrEn   = 1'b0;
        regWrData = ~wdata;
        regRdEn   = 1'b1;
        @(posedge ref_clk);
        #1;
        regRdEn   = 1'b0;
        data      = regRdData;
        valid     = regRdValid;
    endtask
    // One read: answer stands one cycle, so sample it right after the edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output logic valid);
        @(posedge ref_clk);
        #1;
        regAddr = addr;
        regRdEn = 1'b1;
        @(posedge ref_clk);
        #1;
        regRdEn = 1'b0;
        data    = regRdData;
        valid   = regRdValid;
    endtask
endmodule
`default_nettype wire

// >>> tb/pif_flags_masks_bench.sv
// Self-checking bench for the interrupt flag and mask block
`timescale 1ns/1ps
`default_nettype none
module pif_flags_masks_bench
    import pif_pkg::*;
;
    // ==========================================================
    // Signals
    logic       ref_clk = 1'b0;     // 50 MHz clock
    logic       rst_n   = 1'b0;     // Async reset, active low
    logic [7:0] regAddr;            // Register port, driven by host model
    logic       regWrEn;
    logic       regRdEn;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       regRdValid;
    logic [2:0] swFaultRaw  = 3'h0; // Detector levels
    logic [2:0] swIlimitRaw = 3'h0;
    logic [5:0] primaryEventFlags = 6'h00;
    logic       irq_out_n;
    int         bad_count = 0;      // Mismatches
    int         checked   = 0;      // Comparisons made
    int         cycles    = 0;      // Timeout counter
    // ==========================================================
    // Instances
    pif_flags_masks pif_flags_masks_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .swFaultRaw(swFaultRaw), .swIlimitRaw(swIlimitRaw),
        .primaryEventFlags(primaryEventFlags), .irq_out_n(irq_out_n));
    pif_host_model pif_host_model_inst (.ref_clk(ref_clk), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid));
    // Clock, 20 ns period
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Hang guard: whole run needs a few hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 5000) begin
            bad_count++;
            end_sim();
        end
    end
    // ==========================================================
    // Shared helpers
    task automatic end_sim;
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read with valid check; valid must stand the cycle after the strobe
    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        pif_host_model_inst.rd(addr, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic irqchk(input logic exp);
        chk({7'h00, irq_out_n}, {7'h00, exp});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        irqchk(1'b1);
        rdchk(PIF_OFS_EVENT_MASK_PRIMARY, 8'h00);
        rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h00);
    endtask
    // Back-to-back write/read, reserved bits, read-only status, unmapped offset
    task automatic t_regs;
        logic [7:0] d;
        logic       v;
        pif_host_model_inst.wrrd(PIF_OFS_EVENT_MASK_PRIMARY, 8'hEA, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, 8'h2A);
        pif_host_model_inst.wr(PIF_OFS_EVENT_MASK_PRIMARY, 8'hFF);
        rdchk(PIF_OFS_EVENT_MASK_PRIMARY, 8'h3F);
        pif_host_model_inst.wr(PIF_OFS_SWITCH_FAULT_STATUS, 8'hFF);
        rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h00);
        rdchk(8'h07, 8'h00);
    endtask
    // Each mask bit gates exactly its own event
    task automatic t_prim;
        for (int i = 0; i < 6; i++) begin
            pif_host_model_inst.wr(PIF_OFS_EVENT_MASK_PRIMARY, 8'h3F ^ (8'h01 << i));
            primaryEventFlags = 6'h01 << i;
            waitc(2);
            irqchk(1'b0);
            pif_host_model_inst.wr(PIF_OFS_EVENT_MASK_PRIMARY, 8'h01 << i);
            waitc(2);
            irqchk(1'b1);
            primaryEventFlags = 6'h00;
        end
    endtask
    // Sticky faults captured with every primary event masked
    task automatic t_fault;
        pif_host_model_inst.wr(PIF_OFS_EVENT_MASK_PRIMARY, 8'h3F);
        primaryEventFlags = 6'h3F;
        for (int i = 0; i < 3; i++) begin
            swFaultRaw = 3'h1 << i;
            waitc(7);
            irqchk(1'b0);
            rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h08 << i);
            swFaultRaw = 3'h0;
            waitc(7);
            rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h08 << i);
            rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h00);
            waitc(2);
            irqchk(1'b1);
        end
        primaryEventFlags = 6'h00;
    endtask
    // Current-limit flags follow the live level
    task automatic t_limit;
        for (int i = 0; i < 3; i++) begin
            swIlimitRaw = 3'h1 << i;
            waitc(7);
            rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h01 << i);
            irqchk(1'b0);
            swIlimitRaw = 3'h0;
            waitc(7);
            rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h00);
        end
    endtask
    // Mid-run reset returns masks to unmasked and drops latched faults
    task automatic t_midreset;
        pif_host_model_inst.wr(PIF_OFS_EVENT_MASK_PRIMARY, 8'h15);
        swFaultRaw = 3'h4;
        waitc(7);
        irqchk(1'b0);
        swFaultRaw = 3'h0;
        rst_n = 1'b0;
        waitc(2);
        irqchk(1'b1);
        rst_n = 1'b1;
        rdchk(PIF_OFS_EVENT_MASK_PRIMARY, 8'h00);
        rdchk(PIF_OFS_SWITCH_FAULT_STATUS, 8'h00);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_prim();
        t_fault();
        t_limit();
        t_midreset();
        end_sim();
    end
endmodule
`default_nettype wire
